// ===== design/csi_frame_count_forward_cfg.sv
// Configuration slice: frame sync periods, frame numbering, lane rate and port forwarding.
// Assumes the serial control bus engine and the raw frame builder share this clock.
module csi_frame_count_forward_cfg import fwd_cfg_pkg::*; (
  // Clock and reset.
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Register port from the serial control bus engine.
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Raw mode frame builder.
  input  wire logic              raw_mode_i,
  input  wire logic              frame_start_i,
  input  wire logic              frame_end_i,
  output logic      [NUM_W-1:0]  frame_number_o,
  // Configuration towards the forwarding engines and transmitter.
  output logic      [1:0]        lane_rate_o,
  output logic      [PORTS-1:0]  forward_off_o,
  output logic      [PORTS-1:0]  output_route_o,
  output logic                   frame_sync_pulse_o
);

  logic [1:0]        shape_ff;
  logic [1:0]        nxt_shape;
  logic [7:0]        high_up_ff;
  logic [7:0]        nxt_high_up;
  logic [7:0]        high_lo_ff;
  logic [7:0]        nxt_high_lo;
  logic [7:0]        low_up_ff;
  logic [7:0]        nxt_low_up;
  logic [7:0]        low_lo_ff;
  logic [7:0]        nxt_low_lo;
  logic [7:0]        lim_up_ff;
  logic [7:0]        nxt_lim_up;
  logic [7:0]        lim_lo_ff;
  logic [7:0]        nxt_lim_lo;
  lane_rate_e        rate_ff;
  lane_rate_e        nxt_rate;
  logic              rate_rsv_ff;
  logic              nxt_rate_rsv;
  logic [PORTS-1:0]  off_ff;
  logic [PORTS-1:0]  nxt_off;
  logic [PORTS-1:0]  route_ff;
  logic [PORTS-1:0]  nxt_route;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [NUM_W-1:0]  num_ff;
  logic [NUM_W-1:0]  nxt_num;
  logic              in_frame_ff;
  logic              nxt_in_frame;
  logic [NUM_W-1:0]  limit;
  logic              take_start;
  sync_cfg_s         sync_cfg;

  // Register writes; the reserved bits 7:3 of the lane rate register are not stored.
  always_comb begin
    nxt_shape    = shape_ff;
    nxt_high_up  = high_up_ff;
    nxt_high_lo  = high_lo_ff;
    nxt_low_up   = low_up_ff;
    nxt_low_lo   = low_lo_ff;
    nxt_lim_up   = lim_up_ff;
    nxt_lim_lo   = lim_lo_ff;
    nxt_rate     = rate_ff;
    nxt_rate_rsv = rate_rsv_ff;
    nxt_off      = off_ff;
    nxt_route    = route_ff;
    if (reg_wr_i) begin
      case (reg_addr_i)
        SHAPE_CTL_OFS:  nxt_shape   = reg_wdata_i[SHAPE_MODE_BIT:SHAPE_EN_BIT];
        HIGH_UPPER_OFS: nxt_high_up = reg_wdata_i;
        HIGH_LOWER_OFS: nxt_high_lo = reg_wdata_i;
        LOW_UPPER_OFS:  nxt_low_up  = reg_wdata_i;
        LOW_LOWER_OFS:  nxt_low_lo  = reg_wdata_i;
        LIM_UPPER_OFS:  nxt_lim_up  = reg_wdata_i;
        LIM_LOWER_OFS:  nxt_lim_lo  = reg_wdata_i;
        RATE_CTL_OFS: begin
          nxt_rate     = lane_rate_e'(reg_wdata_i[RATE_LSB+1:RATE_LSB]);
          nxt_rate_rsv = reg_wdata_i[RATE_RSV_BIT];
        end
        FWD_CTL_OFS: begin
          nxt_off   = reg_wdata_i[FWD_OFF_LSB+PORTS-1:FWD_OFF_LSB];
          nxt_route = reg_wdata_i[ROUTE_LSB+PORTS-1:ROUTE_LSB];
        end
        default: begin
          nxt_shape = shape_ff;
        end
      endcase
    end
  end

  // Read data is captured one cycle after the strobe and held until the next read.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        SHAPE_CTL_OFS:  nxt_rdata = {6'h00, shape_ff};
        HIGH_UPPER_OFS: nxt_rdata = high_up_ff;
        HIGH_LOWER_OFS: nxt_rdata = high_lo_ff;
        LOW_UPPER_OFS:  nxt_rdata = low_up_ff;
        LOW_LOWER_OFS:  nxt_rdata = low_lo_ff;
        LIM_UPPER_OFS:  nxt_rdata = lim_up_ff;
        LIM_LOWER_OFS:  nxt_rdata = lim_lo_ff;
        RATE_CTL_OFS:   nxt_rdata = {5'h00, rate_rsv_ff, rate_ff};
        FWD_CTL_OFS:    nxt_rdata = {off_ff, route_ff};
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  // Configuration registers with their documented reset values.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shape_ff    <= SHAPE_RST;
      high_up_ff  <= BYTE_RST;
      high_lo_ff  <= BYTE_RST;
      low_up_ff   <= BYTE_RST;
      low_lo_ff   <= BYTE_RST;
      lim_up_ff   <= LIM_UPPER_RST;
      lim_lo_ff   <= LIM_LOWER_RST;
      rate_ff     <= RATE_RST;
      rate_rsv_ff <= 1'b0;
      off_ff      <= FWD_OFF_RST;
      route_ff    <= ROUTE_RST;
      rdata_ff    <= BYTE_RST;
    end else begin
      shape_ff    <= nxt_shape;
      high_up_ff  <= nxt_high_up;
      high_lo_ff  <= nxt_high_lo;
      low_up_ff   <= nxt_low_up;
      low_lo_ff   <= nxt_low_lo;
      lim_up_ff   <= nxt_lim_up;
      lim_lo_ff   <= nxt_lim_lo;
      rate_ff     <= nxt_rate;
      rate_rsv_ff <= nxt_rate_rsv;
      off_ff      <= nxt_off;
      route_ff    <= nxt_route;
      rdata_ff    <= nxt_rdata;
    end
  end

  // Frame numbering. The number is chosen at frame start and held until the next start,
  // so the end packet reuses it; a start seen inside an open frame is ignored.
  assign limit      = {lim_up_ff, lim_lo_ff};
  assign take_start = frame_start_i && raw_mode_i && !in_frame_ff;

  always_comb begin
    nxt_num      = num_ff;
    nxt_in_frame = in_frame_ff;
    if (take_start) begin
      nxt_in_frame = 1'b1;
      if (limit == '0) begin
        nxt_num = NUM_RST;
      end else if (num_ff == '0 || num_ff >= limit) begin
        nxt_num = NUM_FIRST;
      end else begin
        nxt_num = num_ff + 1'b1;
      end
    end else if (frame_end_i) begin
      nxt_in_frame = 1'b0;
    end
  end

  // Frame counter registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      num_ff      <= NUM_RST;
      in_frame_ff <= 1'b0;
    end else begin
      num_ff      <= nxt_num;
      in_frame_ff <= nxt_in_frame;
    end
  end

  // Frame sync settings bundled for the generator; one process drives the whole bundle,
  // because separate continuous assignments to fields of one packed variable are refused.
  always_comb begin
    sync_cfg.enable    = shape_ff[SHAPE_EN_BIT];
    sync_cfg.even_mode = shape_ff[SHAPE_MODE_BIT];
    sync_cfg.high      = {high_up_ff, high_lo_ff};
    sync_cfg.low       = {low_up_ff, low_lo_ff};
  end

  sync_pulse_gen u_sync_gen (
    .ref_clk_i          (ref_clk_i),
    .rst_i              (rst_i),
    .cfg_i              (sync_cfg),
    .frame_sync_pulse_o (frame_sync_pulse_o)
  );

  // Outputs come straight from registers; a route change is only safe while the port is
  // disabled, which this block leaves to software.
  assign reg_rdata_o    = rdata_ff;
  assign frame_number_o = num_ff;
  assign lane_rate_o    = rate_ff;
  assign forward_off_o  = off_ff;
  assign output_route_o = route_ff;

  reset_vals_a: assert property (@(posedge ref_clk_i)
    $fell(rst_i) |-> limit == 16'h0004 && lane_rate_o == 2'h2 && forward_off_o == 4'hF
                     && output_route_o == 4'h0)
    else $error("Configuration did not come out of reset with its defaults.");

  low_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h1B |=> sync_cfg.low[15:8] == $past(reg_wdata_i))
    else $error("Low period upper byte not stored.");

  limit_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h1E |=> limit[7:0] == $past(reg_wdata_i))
    else $error("Frame limit lower byte not stored.");

  rate_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h1F |=> lane_rate_o == $past(reg_wdata_i[1:0]))
    else $error("Lane rate field not taken from bits 1:0.");

  fwd_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == 8'h20 |=> forward_off_o == $past(reg_wdata_i[7:4])
                                        && output_route_o == $past(reg_wdata_i[3:0]))
    else $error("Forwarding register fields misplaced.");

  num_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take_start && limit == '0 |=> frame_number_o == '0)
    else $error("Frame number not zero with numbering disabled.");

  num_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take_start && limit != '0 && frame_number_o >= limit |=> frame_number_o == 16'h0001)
    else $error("Frame number did not wrap to one.");

  num_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take_start && frame_number_o != '0 && frame_number_o < limit
    |=> frame_number_o == $past(frame_number_o) + 16'h0001)
    else $error("Frame number did not advance by one.");

  num_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    in_frame_ff |=> $stable(frame_number_o))
    else $error("Frame number changed inside a frame.");

endmodule

// ===== design/sync_pulse_gen.sv
// Frame sync pulse generator with separate or shared high and low periods.
// Assumes its settings come from registers on the same clock.
module sync_pulse_gen import fwd_cfg_pkg::*; (
  // Clock and reset.
  input  wire logic      ref_clk_i,
  input  wire logic      rst_i,
  // Settings.
  input  wire sync_cfg_s cfg_i,
  // Generated frame sync pulse.
  output logic           frame_sync_pulse_o
);

  sync_phase_e         phase_ff;
  sync_phase_e         nxt_phase;
  logic [PERIOD_W-1:0] cnt_ff;
  logic [PERIOD_W-1:0] nxt_cnt;
  logic                out_ff;
  logic                nxt_out;
  logic [PERIOD_W-1:0] high_len;
  logic [PERIOD_W-1:0] low_len;

  // In even mode one 24-bit value sets both phases; it reuses high byte 0 and both low bytes.
  always_comb begin
    if (cfg_i.even_mode) begin
      high_len = {cfg_i.high[7:0], cfg_i.low};
      low_len  = {cfg_i.high[7:0], cfg_i.low};
    end else begin
      high_len = {8'h00, cfg_i.high};
      low_len  = {8'h00, cfg_i.low};
    end
  end

  // A count of N holds its phase for N+1 cycles, so zero still gives one cycle.
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff;
    nxt_out   = out_ff;
    if (!cfg_i.enable) begin
      nxt_phase = PH_IDLE;
      nxt_cnt   = '0;
      nxt_out   = 1'b0;
    end else begin
      case (phase_ff)
        PH_IDLE: begin
          nxt_phase = PH_HIGH;
          nxt_cnt   = high_len;
          nxt_out   = 1'b1;
        end
        PH_HIGH: begin
          if (cnt_ff == '0) begin
            nxt_phase = PH_LOW;
            nxt_cnt   = low_len;
            nxt_out   = 1'b0;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        PH_LOW: begin
          if (cnt_ff == '0) begin
            nxt_phase = PH_HIGH;
            nxt_cnt   = high_len;
            nxt_out   = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        default: begin
          nxt_phase = PH_IDLE;
          nxt_cnt   = '0;
          nxt_out   = 1'b0;
        end
      endcase
    end
  end

  // Generator state registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= PH_IDLE;
      cnt_ff   <= '0;
      out_ff   <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff   <= nxt_cnt;
      out_ff   <= nxt_out;
    end
  end

  assign frame_sync_pulse_o = out_ff;

  high_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    phase_ff == PH_HIGH && cnt_ff == '0 && cfg_i.enable |=> !frame_sync_pulse_o)
    else $error("High phase did not end when its count ran out.");

  low_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    phase_ff == PH_LOW && cnt_ff == '0 && cfg_i.enable |=> frame_sync_pulse_o)
    else $error("Low phase did not end when its count ran out.");

  high_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(frame_sync_pulse_o) |-> cnt_ff == $past(high_len))
    else $error("High phase loaded the wrong period.");

endmodule

// ===== inc/fwd_cfg_pkg.sv
// Shared constants and types for the frame count and forwarding configuration block.
// Assumes one 8-bit register port driven by the serial control bus engine on the same clock.
package fwd_cfg_pkg;

  // Register port, forwarding port, frame number and sync period widths.
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PORTS    = 4;
  localparam int unsigned NUM_W    = 16;
  localparam int unsigned PERIOD_W = 24;

  // Register offsets.
  localparam logic [7:0] SHAPE_CTL_OFS  = 8'h18;
  localparam logic [7:0] HIGH_UPPER_OFS = 8'h19;
  localparam logic [7:0] HIGH_LOWER_OFS = 8'h1A;
  localparam logic [7:0] LOW_UPPER_OFS  = 8'h1B;
  localparam logic [7:0] LOW_LOWER_OFS  = 8'h1C;
  localparam logic [7:0] LIM_UPPER_OFS  = 8'h1D;
  localparam logic [7:0] LIM_LOWER_OFS  = 8'h1E;
  localparam logic [7:0] RATE_CTL_OFS   = 8'h1F;
  localparam logic [7:0] FWD_CTL_OFS    = 8'h20;

  // Field positions.
  localparam int unsigned SHAPE_EN_BIT   = 0;
  localparam int unsigned SHAPE_MODE_BIT = 1;
  localparam int unsigned RATE_LSB       = 0;
  localparam int unsigned RATE_RSV_BIT   = 2;
  localparam int unsigned ROUTE_LSB      = 0;
  localparam int unsigned FWD_OFF_LSB    = 4;

  // Reset values.
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [7:0] LIM_LOWER_RST = 8'h04;
  localparam logic [7:0] LIM_UPPER_RST = 8'h00;
  localparam logic [1:0] SHAPE_RST     = 2'h0;
  localparam logic [3:0] FWD_OFF_RST   = 4'hF;
  localparam logic [3:0] ROUTE_RST     = 4'h0;
  localparam logic [15:0] NUM_RST      = 16'h0000;
  localparam logic [15:0] NUM_FIRST    = 16'h0001;

  // Lane rate encodings of the transmitter speed field.
  typedef enum logic [1:0] {
    RATE_1G5  = 2'h0,
    RATE_RSV  = 2'h1,
    RATE_800M = 2'h2,
    RATE_400M = 2'h3
  } lane_rate_e;

  localparam lane_rate_e RATE_RST = RATE_800M;

  // Phases of the frame sync generator.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HIGH,
    PH_LOW
  } sync_phase_e;

  // Frame sync generator settings carried as one bundle.
  typedef struct packed {
    logic        enable;
    logic        even_mode;
    logic [15:0] high;
    logic [15:0] low;
  } sync_cfg_s;

endpackage

// ===== testbench/frame_source.sv
// Raw frame builder model that frames video and reads the frame number back.
// Assumes the block's frame number output is registered on the same clock.
module frame_source (
  // Clock.
  input  wire logic        ref_clk_i,
  // Number offered by the block.
  input  wire logic [15:0] frame_number_i,
  // Frame strobes towards the block.
  output logic             raw_mode_o,
  output logic             frame_start_o,
  output logic             frame_end_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Strobes idle low from time zero.
  initial begin
    raw_mode_o    = 1'b0;
    frame_start_o = 1'b0;
    frame_end_o   = 1'b0;
  end

  // Sets or clears raw mode between frames only.
  task automatic set_raw(input logic on);
    @(posedge ref_clk_i);
    raw_mode_o <= on;
  endtask

  // One frame: a start pulse, an optional stray start, then an end pulse.
  task automatic send_frame(input logic dup, output logic [15:0] n_s,
                            output logic [15:0] n_e);
    @(posedge ref_clk_i);
    frame_start_o <= 1'b1;
    @(posedge ref_clk_i);
    frame_start_o <= dup;
    @(posedge ref_clk_i);
    frame_start_o <= 1'b0;
    #1;
    n_s = frame_number_i;
    @(posedge ref_clk_i);
    frame_end_o <= 1'b1;
    @(posedge ref_clk_i);
    frame_end_o <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    n_e = frame_number_i;
  endtask
endmodule

// ===== testbench/tb_csi_frame_count_forward_cfg.sv
// Self-checking bench for the configuration slice and its frame numbering.
// Assumes the frame_source model drives the raw frame builder inputs.
module tb_csi_frame_count_forward_cfg;
  timeunit 1ns;
  timeprecision 100ps;
  import fwd_cfg_pkg::*;

  logic        ref_clk_i;
  logic        rst_i;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        raw_mode_i;
  logic        frame_start_i;
  logic        frame_end_i;
  logic [15:0] frame_number_o;
  logic [1:0]  lane_rate_o;
  logic [3:0]  forward_off_o;
  logic [3:0]  output_route_o;
  logic        frame_sync_pulse_o;
  int          err_total;
  int          n_compared;

  csi_frame_count_forward_cfg csi_frame_count_forward_cfg_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .raw_mode_i(raw_mode_i),
    .frame_start_i(frame_start_i), .frame_end_i(frame_end_i),
    .frame_number_o(frame_number_o), .lane_rate_o(lane_rate_o),
    .forward_off_o(forward_off_o), .output_route_o(output_route_o),
    .frame_sync_pulse_o(frame_sync_pulse_o));

  frame_source frame_source_inst (
    .ref_clk_i(ref_clk_i), .frame_number_i(frame_number_o),
    .raw_mode_o(raw_mode_i), .frame_start_o(frame_start_i),
    .frame_end_o(frame_end_i));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Shared comparison; narrower results are zero-extended into it.
  task automatic cmp_num(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_num({8'h00, got}, {8'h00, exp});
  endtask

  task automatic cmp_cfg(input logic [3:0] got, input logic [3:0] exp);
    cmp_num({12'h000, got}, {12'h000, exp});
  endtask

  // One write strobe, then one settled cycle so outputs can be sampled.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    cmp_byte(reg_rdata_o, exp);
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compared=%0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset values of the low, limit, rate and forwarding bytes, an unmapped read and the idle outputs.
  task automatic reset_values;
    reg_check(LOW_UPPER_OFS, 8'h00);
    reg_check(LOW_LOWER_OFS, 8'h00);
    reg_check(LIM_UPPER_OFS, 8'h00);
    reg_check(LIM_LOWER_OFS, 8'h04);
    reg_check(RATE_CTL_OFS, 8'h02);
    reg_check(FWD_CTL_OFS, 8'hF0);
    reg_check(8'h30, 8'h00);
    cmp_cfg({2'h0, lane_rate_o}, 4'h2);
    cmp_cfg(forward_off_o, 4'hF);
    cmp_cfg(output_route_o, 4'h0);
    cmp_num(frame_number_o, 16'h0000);
  endtask

  // Byte registers hold their own halves; reserved bits 7:3 of the rate byte read 0 and bit 2 reads back.
  task automatic reg_access;
    reg_write(LOW_UPPER_OFS, 8'hA5);
    reg_write(LOW_LOWER_OFS, 8'h5A);
    reg_check(LOW_UPPER_OFS, 8'hA5);
    reg_check(LOW_LOWER_OFS, 8'h5A);
    reg_write(RATE_CTL_OFS, 8'hFF);
    reg_check(RATE_CTL_OFS, 8'h07);
    for (int r = 0; r < 4; r++) begin
      reg_write(RATE_CTL_OFS, 8'(r));
      cmp_cfg({2'h0, lane_rate_o}, 4'(r));
    end
  endtask

  // Route changes are made with forwarding off, then forwarding is opened.
  task automatic forward_route;
    reg_write(FWD_CTL_OFS, 8'hF5);
    cmp_cfg(output_route_o, 4'h5);
    cmp_cfg(forward_off_o, 4'hF);
    reg_write(FWD_CTL_OFS, 8'h65);
    cmp_cfg(forward_off_o, 4'h6);
    reg_write(FWD_CTL_OFS, 8'hFA);
    reg_write(FWD_CTL_OFS, 8'h0A);
    cmp_cfg(forward_off_o, 4'h0);
    cmp_cfg(output_route_o, 4'hA);
    reg_check(FWD_CTL_OFS, 8'h0A);
  endtask

  // Numbering wraps at the limit, ignores stray starts and idle raw mode.
  task automatic frame_count;
    logic [15:0] ns;
    logic [15:0] ne;
    reg_write(LIM_LOWER_OFS, 8'h03);
    frame_source_inst.set_raw(1'b1);
    for (int i = 0; i < 5; i++) begin
      frame_source_inst.send_frame(i == 1, ns, ne);
      cmp_num(ns, 16'((i % 3) + 1));
      cmp_num(ne, 16'((i % 3) + 1));
    end
    frame_source_inst.set_raw(1'b0);
    frame_source_inst.send_frame(1'b0, ns, ne);
    cmp_num(ns, 16'h0002);
    frame_source_inst.set_raw(1'b1);
    reg_write(LIM_LOWER_OFS, 8'h00);
    frame_source_inst.send_frame(1'b0, ns, ne);
    cmp_num(ns, 16'h0000);
    reg_write(LIM_UPPER_OFS, 8'h01);
    frame_source_inst.send_frame(1'b0, ns, ne);
    cmp_num(ns, 16'h0001);
    frame_source_inst.send_frame(1'b0, ns, ne);
    cmp_num(ns, 16'h0002);
  endtask

  // Measures one high and one low phase of the generator in cycles.
  // In even mode the high lower byte is the top byte of the shared 24-bit count.
  task automatic sync_shape(input logic [7:0] ctl, input logic [7:0] hi_l,
                            input logic [7:0] lo_l,
                            input logic [15:0] e_hi, input logic [15:0] e_lo);
    logic [15:0] nh;
    logic [15:0] nl;
    nh = 16'h0000;
    nl = 16'h0000;
    reg_write(HIGH_LOWER_OFS, hi_l);
    reg_write(LOW_UPPER_OFS, 8'h00);
    reg_write(LOW_LOWER_OFS, lo_l);
    reg_write(SHAPE_CTL_OFS, ctl);
    for (int k = 0; k < 40 && frame_sync_pulse_o !== 1'b0; k++) @(posedge ref_clk_i) #1;
    for (int k = 0; k < 40 && frame_sync_pulse_o !== 1'b1; k++) @(posedge ref_clk_i) #1;
    while (frame_sync_pulse_o === 1'b1 && nh < 40) begin
      nh++;
      @(posedge ref_clk_i) #1;
    end
    while (frame_sync_pulse_o === 1'b0 && nl < 40) begin
      nl++;
      @(posedge ref_clk_i) #1;
    end
    cmp_num(nh, e_hi);
    cmp_num(nl, e_lo);
    reg_write(SHAPE_CTL_OFS, 8'h00);
  endtask

  // Main sequence.
  initial begin
    err_total   = 0;
    n_compared  = 0;
    rst_i       = 1'b1;
    reg_addr_i  = 8'h00;
    reg_wr_i    = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i    = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reset_values();
    reg_access();
    forward_route();
    frame_count();
    sync_shape(8'h01, 8'h01, 8'h00, 16'h0002, 16'h0001);
    sync_shape(8'h01, 8'h01, 8'h03, 16'h0002, 16'h0004);
    sync_shape(8'h03, 8'h00, 8'h02, 16'h0003, 16'h0003);
    tally_and_finish();
  end

  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule
